// file: ssc_regs.svh
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// Command codes of the three configuration registers
`define SSC_CMD_SYNC_SETUP 8'he4
`define SSC_CMD_STACK_SETUP 8'hec
`define SSC_CMD_MISC_SETTINGS 8'hed

// Sync setup field positions
`define SSC_SYNC_DIR_HI 7
`define SSC_SYNC_DIR_LO 6
`define SSC_SYNC_EDGE_BIT 5
`define SSC_SYNC_FILL_HI 4
`define SSC_SYNC_FILL 5'h10

// Sync direction codes
`define SSC_DIR_OFF 2'h0
`define SSC_DIR_OUT 2'h1
`define SSC_DIR_IN 2'h2
`define SSC_DIR_AUTO 2'h3

// Phase stack setup fields
`define SSC_STACK_LAST_HI 3
`define SSC_STACK_LAST_MAX 4'h3
`define SSC_STACK_FIRST_INDEX 4'h0
`define SSC_STACK_UPPER 8'h00

// Strap precedence control bits
`define SSC_OVR_STACK_BIT 12
`define SSC_OVR_SYNC_BIT 11

// Reset contents; sync and stack held until the power-up load, misc until written
`define SSC_SYNC_RESET 8'h50
`define SSC_STACK_RESET 4'h0
`define SSC_MISC_RESET 16'h0000

// Sync toggling test: faster than 75 percent of the set frequency
`define SSC_FREQ_NUM 18'd3
`define SSC_FREQ_DEN 18'd4
`define SSC_EDGE_CNT_MAX 16'hffff

`endif

// file: ssc_pkg.sv
package ssc_pkg;

    // Resolved sync direction
    typedef enum logic [1:0] {
        SSC_MODE_OFF = 2'b00,
        SSC_MODE_OUT = 2'b01,
        SSC_MODE_IN = 2'b10
    } ssc_sync_mode_t;

    // Decoded command from the bus transaction layer
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } ssc_cmd_t;

    // Read answer
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } ssc_rsp_t;

    // Values offered at power-up or restore
    typedef struct packed {
        logic [15:0] precedence;
        logic [7:0] nvm_sync;
        logic [7:0] pin_sync;
        logic [3:0] nvm_last;
        logic [3:0] pin_last;
    } ssc_load_t;

    // Backchannel pin group
    typedef struct packed {
        logic clk_out;
        logic clk_oe;
        logic dat_out;
        logic dat_oe;
    } ssc_bcx_pins_t;

endpackage

// file: ssc_bcx_link.sv
`timescale 1ns/1ps
module ssc_bcx_link (
    // Link clock and reset
    input wire logic backchannel_clock_pin_in,
    input wire logic sys_rst_in,
    // From the core domain, held stable
    input wire logic active_in,
    input wire logic idx_toggle_in,
    input wire logic [3:0] last_idx_in,
    // Backchannel data pin input
    input wire logic dat_in,
    // Pin drive
    output ssc_pkg::ssc_bcx_pins_t pins_out
);
    import ssc_pkg::*;

    typedef struct packed {
        logic act_m1;
        logic act_m2;
        logic tgl_m1;
        logic tgl_m2;
        logic tgl_prev;
        logic [3:0] idx;
        logic [3:0] shift;
        logic [1:0] bitcnt;
        logic rx_m1;
        logic rx_m2;
        ssc_bcx_pins_t pins;
    } ssc_link_state_t;

    ssc_link_state_t link_q, link_d;

    // Next state: clock toggles and index frame shifts while active
    always_comb begin
        link_d = link_q;
        link_d.act_m1 = active_in;
        link_d.act_m2 = link_q.act_m1;
        link_d.tgl_m1 = idx_toggle_in;
        link_d.tgl_m2 = link_q.tgl_m1;
        link_d.tgl_prev = link_q.tgl_m2;
        link_d.rx_m1 = dat_in;
        link_d.rx_m2 = link_q.rx_m1;
        // Index is quasi-static in the core domain when the toggle lands
        if (link_q.tgl_m2 != link_q.tgl_prev) begin
            link_d.idx = last_idx_in;
        end
        if (link_q.act_m2) begin
            link_d.pins.clk_out = ~link_q.pins.clk_out;
            link_d.pins.clk_oe = 1'b1;
            link_d.pins.dat_oe = 1'b1;
            if (link_q.pins.clk_out) begin
                link_d.pins.dat_out = link_q.shift[3];
                link_d.shift = (link_q.bitcnt == 2'h3) ? link_q.idx : {link_q.shift[2:0], 1'b0};
                link_d.bitcnt = link_q.bitcnt + 2'h1;
            end
        end else begin
            link_d.pins = '0;
            link_d.bitcnt = 2'h0;
            link_d.shift = link_q.idx;
        end
    end

    // State register on the link clock
    always_ff @(posedge backchannel_clock_pin_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    assign pins_out = link_q.pins;

    link_idle_a: assert property (@(posedge backchannel_clock_pin_in) disable iff (sys_rst_in)
        !link_q.act_m2 |=> !pins_out.clk_oe && !pins_out.dat_oe)
        else $error("backchannel pins driven while inactive");

endmodule // ssc_bcx_link

// file: ssc_top.sv
// Summary of operation
// - Sync direction bits 7:6: 00 off, 01 output, 10 input, 11 auto-detect.
// - Edge select bit 5: 0 locks to falling edge, 1 to rising edge.
// - Undefined sync setup writes flag invalid data and alert the host.
// - Auto-detect decides direction only when the enable condition becomes true.
// - Auto-detect picks input if pin high or toggling fast, else output.
// - Followers always use sync input and flag sync loss when sync absent while conversion is enabled.
// - Input-to-output change at low limit keeps 70% frequency until conversion is disabled.
// - Input-to-output change during sync fault runs oscillator at 70%.
// - Stack setup upper byte is read-only zero.
// - Stack bits 7:4 are read-only first index, always zero.
// - Last index bits 3:0: 0 to 3 give one to four phases.
// - Undefined stack setup writes flag invalid data and alert the host.
// - Stack setup is writable only while conversion is disabled.
// - Standalone stack value at power-up keeps backchannel pins inactive.
// - Backchannel enabled state changes only at the next power-up.
// - Backchannel active from power-up accepts live changes 0 through 3.
// - Stack value loads from store or strap per override bit 12.
// - Sync value loads from store or strap per override bit 11.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_top (
    // Clocks and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic backchannel_clock_pin_in,
    // Command port
    input wire ssc_pkg::ssc_cmd_t cmd_in,
    output ssc_pkg::ssc_rsp_t rsp_out,
    output logic cml_invalid_data_out,
    output logic cml_invalid_cmd_out,
    // Power-up and restore loading
    input wire ssc_pkg::ssc_load_t load_in,
    input wire logic restore_in,
    // Converter state
    input wire logic conv_enable_in,
    input wire logic follower_in,
    input wire logic sync_at_low_limit_in,
    input wire logic [15:0] switching_period_in,
    input wire logic sync_fault_clear_in,
    // Sync pin
    input wire logic sync_pin_in,
    output ssc_pkg::ssc_sync_mode_t sync_mode_out,
    output logic sync_edge_rising_out,
    output logic sync_loss_fault_out,
    output logic osc_low_rate_out,
    // Miscellaneous settings word
    output logic [15:0] misc_settings_out,
    // Backchannel pins
    input wire logic backchannel_data_pin_in,
    output ssc_pkg::ssc_bcx_pins_t backchannel_pins_out
);
    import ssc_pkg::*;

    typedef struct packed {
        logic init_done;
        logic [7:0] sync_cfg;
        logic [15:0] misc;
        logic [3:0] last_idx;
        logic bcx_active;
        logic idx_tgl;
        ssc_rsp_t rsp;
        logic inv_data;
        logic inv_cmd;
        logic sync_m1;
        logic sync_m2;
        logic sync_prev;
        logic [15:0] edge_cnt;
        logic toggling;
        logic en_prev;
        logic auto_in;
        ssc_sync_mode_t mode;
        logic edge_rise;
        logic fault;
        logic hold_low;
    } ssc_state_t;

    ssc_state_t st_q, st_d;

    // True when an interval of cnt cycles is shorter than 4/3 of the set period
    function automatic logic ssc_faster(input logic [15:0] cnt, input logic [15:0] period);
        logic [17:0] lhs;
        logic [17:0] rhs;
        lhs = {2'b00, cnt} * `SSC_FREQ_NUM;
        rhs = {2'b00, period} * `SSC_FREQ_DEN;
        return (lhs < rhs);
    endfunction

    // A sync setup byte is legal only with the fixed low pattern
    function automatic logic ssc_sync_ok(input logic [15:0] w);
        return (w[15:8] == 8'h00) && (w[`SSC_SYNC_FILL_HI:0] == `SSC_SYNC_FILL);
    endfunction

    logic sync_rise;
    logic en_rise;
    logic [3:0] boot_last;
    logic [1:0] new_dir;

    // Next state of the whole block
    always_comb begin
        st_d = st_q;
        sync_rise = st_q.sync_m2 & ~st_q.sync_prev;
        en_rise = conv_enable_in & ~st_q.en_prev;
        boot_last = load_in.precedence[`SSC_OVR_STACK_BIT] ? load_in.pin_last : load_in.nvm_last;
        new_dir = cmd_in.wdata[`SSC_SYNC_DIR_HI:`SSC_SYNC_DIR_LO];
        st_d.rsp = '0;
        st_d.inv_data = 1'b0;
        st_d.inv_cmd = 1'b0;

        // Pin synchroniser; only the second stage is looked at
        st_d.sync_m1 = sync_pin_in;
        st_d.sync_m2 = st_q.sync_m1;
        st_d.sync_prev = st_q.sync_m2;

        // Rising-edge interval measure; toggling drops once the gap grows too long
        if (sync_rise) begin
            st_d.edge_cnt = 16'h0000;
            st_d.toggling = ssc_faster(st_q.edge_cnt, switching_period_in);
        end else begin
            if (st_q.edge_cnt != `SSC_EDGE_CNT_MAX) begin
                st_d.edge_cnt = st_q.edge_cnt + 16'h0001;
            end
            if (!ssc_faster(st_q.edge_cnt, switching_period_in)) begin
                st_d.toggling = 1'b0;
            end
        end

        // Power-up and restore load; strap or stored value per precedence bit
        st_d.init_done = 1'b1;
        if (!st_q.init_done || restore_in) begin
            st_d.sync_cfg = load_in.precedence[`SSC_OVR_SYNC_BIT] ? load_in.pin_sync : load_in.nvm_sync;
            st_d.last_idx = boot_last;
            // A restore in a running stack must refresh the index on the link as well
            if (st_q.bcx_active) begin
                st_d.idx_tgl = ~st_q.idx_tgl;
            end
        end
        // Backchannel enable is decided once, at power-up only
        if (!st_q.init_done) begin
            st_d.bcx_active = (boot_last != `SSC_STACK_RESET);
            st_d.idx_tgl = ~st_q.idx_tgl;
        end

        // Command handling; answers and flags come one cycle after the request
        if (cmd_in.valid && st_q.init_done) begin
            st_d.rsp.valid = ~cmd_in.write;
            if (cmd_in.code == `SSC_CMD_SYNC_SETUP) begin
                st_d.rsp.data = {8'h00, st_q.sync_cfg};
                if (cmd_in.write) begin
                    if (ssc_sync_ok(cmd_in.wdata)) begin
                        st_d.sync_cfg = cmd_in.wdata[7:0];
                        if (st_q.sync_cfg[`SSC_SYNC_DIR_HI:`SSC_SYNC_DIR_LO] == `SSC_DIR_IN &&
                            new_dir == `SSC_DIR_OUT && conv_enable_in &&
                            (sync_at_low_limit_in || st_q.fault)) begin
                            st_d.hold_low = 1'b1;
                        end
                    end else begin
                        st_d.inv_data = 1'b1;
                    end
                end
            end else if (cmd_in.code == `SSC_CMD_STACK_SETUP) begin
                st_d.rsp.data = {`SSC_STACK_UPPER, `SSC_STACK_FIRST_INDEX, st_q.last_idx};
                if (cmd_in.write) begin
                    if (conv_enable_in) begin
                        st_d.inv_cmd = 1'b1;
                    end else if (cmd_in.wdata[15:4] == 12'h000 &&
                                 cmd_in.wdata[`SSC_STACK_LAST_HI:0] <= `SSC_STACK_LAST_MAX) begin
                        st_d.last_idx = cmd_in.wdata[`SSC_STACK_LAST_HI:0];
                        // Live change reaches the link only if it came up active
                        if (st_q.bcx_active) begin
                            st_d.idx_tgl = ~st_q.idx_tgl;
                        end
                    end else begin
                        st_d.inv_data = 1'b1;
                    end
                end
            end else if (cmd_in.code == `SSC_CMD_MISC_SETTINGS) begin
                st_d.rsp.data = st_q.misc;
                if (cmd_in.write) begin
                    st_d.misc = cmd_in.wdata;
                end
            end else begin
                st_d.rsp.data = 16'h0000;
                st_d.inv_cmd = 1'b1;
            end
        end

        // Auto-detect samples the pin only at the enable edge
        st_d.en_prev = conv_enable_in;
        if (en_rise) begin
            st_d.auto_in = st_q.sync_m2 | st_q.toggling;
        end
        if (!conv_enable_in) begin
            st_d.hold_low = 1'b0;
        end

        // Resolved direction; followers are forced to input
        if (follower_in) begin
            st_d.mode = SSC_MODE_IN;
        end else begin
            case (st_q.sync_cfg[`SSC_SYNC_DIR_HI:`SSC_SYNC_DIR_LO])
                `SSC_DIR_OFF: st_d.mode = SSC_MODE_OFF;
                `SSC_DIR_OUT: st_d.mode = SSC_MODE_OUT;
                `SSC_DIR_IN: st_d.mode = SSC_MODE_IN;
                default: st_d.mode = st_q.auto_in ? SSC_MODE_IN : SSC_MODE_OUT;
            endcase
        end
        st_d.edge_rise = st_q.sync_cfg[`SSC_SYNC_EDGE_BIT];

        // Sync loss on a follower; a set in the clear cycle wins
        if (follower_in && conv_enable_in && !st_q.toggling) begin
            st_d.fault = 1'b1;
        end else if (sync_fault_clear_in) begin
            st_d.fault = 1'b0;
        end
    end

    // State register on the core clock
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '{sync_cfg: `SSC_SYNC_RESET, misc: `SSC_MISC_RESET, last_idx: `SSC_STACK_RESET,
                      mode: SSC_MODE_OFF, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign rsp_out = st_q.rsp;
    assign cml_invalid_data_out = st_q.inv_data;
    assign cml_invalid_cmd_out = st_q.inv_cmd;
    assign sync_mode_out = st_q.mode;
    assign sync_edge_rising_out = st_q.edge_rise;
    assign sync_loss_fault_out = st_q.fault;
    assign osc_low_rate_out = st_q.hold_low;
    assign misc_settings_out = st_q.misc;

    // Backchannel logic on its own clock; index passes by toggle handshake
    ssc_bcx_link u_link (
        .backchannel_clock_pin_in(backchannel_clock_pin_in),
        .sys_rst_in(sys_rst_in),
        .active_in(st_q.bcx_active),
        .idx_toggle_in(st_q.idx_tgl),
        .last_idx_in(st_q.last_idx),
        .dat_in(backchannel_data_pin_in),
        .pins_out(backchannel_pins_out)
    );

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    mode_decode_a: assert property (
        st_q.sync_cfg[7:6] == 2'b01 && !follower_in |=> sync_mode_out == SSC_MODE_OUT)
        else $error("sync direction 01 did not resolve to output");

    edge_select_a: assert property (
        st_q.init_done |=> sync_edge_rising_out == $past(st_q.sync_cfg[5]))
        else $error("edge select does not follow bit 5");

    sync_reject_a: assert property (
        st_q.init_done && cmd_in.valid && cmd_in.write && cmd_in.code == 8'he4 && !restore_in &&
        cmd_in.wdata[4:0] != 5'h10
        |=> cml_invalid_data_out && $stable(st_q.sync_cfg))
        else $error("bad sync write not rejected");

    follower_fault_a: assert property (
        follower_in && conv_enable_in && !st_q.toggling |=> sync_loss_fault_out && sync_mode_out == SSC_MODE_IN)
        else $error("follower sync loss not flagged");

    hold_low_a: assert property (
        osc_low_rate_out && conv_enable_in |=> osc_low_rate_out)
        else $error("low rate hold dropped while enabled");

    stack_readback_a: assert property (
        st_q.init_done && cmd_in.valid && !cmd_in.write && cmd_in.code == 8'hec
        |=> rsp_out.valid && rsp_out.data[15:4] == 12'h000)
        else $error("stack setup upper bits not zero");

    stack_range_a: assert property (
        st_q.init_done |-> st_q.last_idx <= 4'h3 || $past(restore_in) || !$past(st_q.init_done))
        else $error("last index out of range");

    stack_locked_a: assert property (
        st_q.init_done && cmd_in.valid && cmd_in.write && cmd_in.code == 8'hec && conv_enable_in && !restore_in
        |=> cml_invalid_cmd_out && $stable(st_q.last_idx))
        else $error("stack setup changed while converting");

    bcx_frozen_a: assert property (
        st_q.init_done && !st_q.bcx_active |=> !st_q.bcx_active)
        else $error("backchannel enabled after power-up");

    stack_reject_a: assert property (
        st_q.init_done && cmd_in.valid && cmd_in.write && cmd_in.code == 8'hec && !conv_enable_in && !restore_in &&
        (cmd_in.wdata[15:4] != 12'h000 || cmd_in.wdata[3:0] > 4'h3)
        |=> cml_invalid_data_out && $stable(st_q.last_idx))
        else $error("bad stack write not rejected");

    auto_pick_c: cover property (en_rise && st_q.sync_cfg[7:6] == 2'b11 && st_q.toggling);
    fault_set_c: cover property (!sync_loss_fault_out ##1 sync_loss_fault_out);
    hold_set_c: cover property (!osc_low_rate_out ##1 osc_low_rate_out);
    live_stack_c: cover property (st_q.bcx_active && cmd_in.valid && cmd_in.write && cmd_in.code == 8'hec);

endmodule // ssc_top

// file: ssc_far_model.sv
`timescale 1ns/1ps
// Far side: an external sync source and one stacked follower on the backchannel
module ssc_far_model (
    // Core clock paces the sync source
    input wire logic core_clk_in,
    // Sync source control
    input wire logic run_in,
    input wire logic level_in,
    input wire logic [7:0] half_in,
    // Backchannel pins from the controller
    input wire ssc_pkg::ssc_bcx_pins_t pins_in,
    // Lines back to the device
    output logic sync_pin_out = 1'b0,
    output logic dat_pin_out,
    output logic [7:0] hist_out = 8'h00
);
    logic [7:0] cnt_q = 8'h00;
    // Static level when stopped, square wave of two half periods when running
    always @(posedge core_clk_in) begin
        if (!run_in) begin
            cnt_q <= 8'h00;
            sync_pin_out <= level_in;
        end else if (cnt_q >= half_in - 8'h01) begin
            cnt_q <= 8'h00;
            sync_pin_out <= ~sync_pin_out;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Data line has a pull-up, so a released line reads high
    assign dat_pin_out = pins_in.dat_oe ? pins_in.dat_out : 1'b1;
    // Sample on the rising clock because data moves on the falling one
    always @(posedge pins_in.clk_out) begin
        if (pins_in.clk_oe) begin
            hist_out <= {hist_out[6:0], pins_in.dat_out};
        end
    end
endmodule // ssc_far_model

// file: tb_ssc_top.sv
`timescale 1ns/1ps
`include "ssc_regs.svh"
// Compare a seen value with the expected one and count the outcome
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_ssc_top;
    import ssc_pkg::*;
    logic core_clk_in = 1'b0, backchannel_clock_pin = 1'b0, sys_rst_in = 1'b1;
    ssc_cmd_t cmd = '0;
    ssc_rsp_t rsp;
    ssc_load_t load = '0;
    ssc_sync_mode_t mode;
    ssc_bcx_pins_t pins;
    logic inv_d, inv_c, edge_r, fault, low_rate, sync_pin, dat_pin;
    logic restore = 1'b0, conv = 1'b0, follower = 1'b0, low_lim = 1'b0, clr = 1'b0, run = 1'b0, level = 1'b0;
    logic [15:0] misc, d;
    logic [7:0] half = 8'h0a, hist;
    int mismatches = 0, total_checks = 0, cycles = 0, m_sync, m_last, m_misc;
    ssc_top ssc_top_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .backchannel_clock_pin_in(backchannel_clock_pin), .cmd_in(cmd),
        .rsp_out(rsp), .cml_invalid_data_out(inv_d), .cml_invalid_cmd_out(inv_c), .load_in(load),
        .restore_in(restore), .conv_enable_in(conv), .follower_in(follower), .sync_at_low_limit_in(low_lim),
        .switching_period_in(16'h0028), .sync_fault_clear_in(clr), .sync_pin_in(sync_pin),
        .sync_mode_out(mode), .sync_edge_rising_out(edge_r), .sync_loss_fault_out(fault),
        .osc_low_rate_out(low_rate), .misc_settings_out(misc), .backchannel_data_pin_in(dat_pin),
        .backchannel_pins_out(pins));
    ssc_far_model ssc_far_model_i (.core_clk_in(core_clk_in), .run_in(run), .level_in(level), .half_in(half),
        .pins_in(pins), .sync_pin_out(sync_pin), .dat_pin_out(dat_pin), .hist_out(hist));
    // Two unrelated clocks: 25 ns core, 12 ns link with an odd phase
    initial forever #12.5 core_clk_in = ~core_clk_in;
    initial begin
        #3.7;
        forever #6 backchannel_clock_pin = ~backchannel_clock_pin;
    end
    // Hang guard, well above the few thousand cycles the tests take
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // Power cycle; the model loads store or strap per the precedence bits
    task automatic power_up(input logic [15:0] prec, input logic [3:0] nl, input logic [3:0] pl);
        sys_rst_in <= 1'b1;
        load <= {prec, 8'h50, 8'hb0, nl, pl};
        tick(8);
        `CHK("reset mode", SSC_MODE_OFF, mode)
        sys_rst_in <= 1'b0;
        m_sync = prec[11] ? 'hb0 : 'h50;
        m_last = prec[12] ? pl : nl;
        m_misc = 0;
        tick(2);
    endtask
    // One command through the model, then the answer checked in its single cycle
    task automatic cmd_do(input logic wr, input logic [7:0] code, input logic [15:0] wd);
        int ed, ec, er;
        ed = 0;
        ec = 0;
        er = 0;
        case (code)
            `SSC_CMD_SYNC_SETUP: begin
                if (!wr) er = m_sync;
                else if (wd[15:8] == 8'h00 && wd[4:0] == 5'h10) m_sync = wd;
                else ed = 1;
            end
            `SSC_CMD_STACK_SETUP: begin
                if (!wr) er = m_last;
                else if (conv) ec = 1;
                else if (wd[15:4] == 12'h000 && wd[3:0] <= 4'h3) m_last = wd[3:0];
                else ed = 1;
            end
            `SSC_CMD_MISC_SETTINGS: begin
                if (!wr) er = m_misc;
                else m_misc = wd;
            end
            default: ec = 1;
        endcase
        cmd <= {1'b1, wr, code, wd};
        @(posedge core_clk_in);
        cmd.valid <= 1'b0;
        #1;
        `CHK("rsp valid", 1'(!wr), rsp.valid)
        if (!wr) `CHK("rsp data", 16'(er), rsp.data)
        `CHK("invalid data", 1'(ed), inv_d)
        `CHK("invalid cmd", 1'(ec), inv_c)
        @(posedge core_clk_in);
    endtask
    task automatic pulse_clr;
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(3);
    endtask
    // True when eight captured bits are the 4-bit index repeated, any phase
    function automatic logic rot_ok(input logic [7:0] h, input int v);
        logic ok;
        ok = 1'b0;
        for (int r = 0; r < 4; r++) if (h === {2{4'(((v << r) | (v >> (4 - r))) & 15)}}) ok = 1'b1;
        return ok;
    endfunction
    initial begin
        void'($urandom(32'h028201c6));
        power_up(16'h0000, 4'h0, 4'h2);
        cmd_do(0, `SSC_CMD_SYNC_SETUP, 0);
        cmd_do(0, `SSC_CMD_STACK_SETUP, 0);
        cmd_do(0, `SSC_CMD_MISC_SETTINGS, 0);
        `CHK("bcx oe", 2'b00, {pins.clk_oe, pins.dat_oe})
        $display("Test power-up done");
        // Every direction and edge; the host keeps the 10000b fill
        for (int i = 0; i < 8; i++) begin
            cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'(i * 32 + 16));
            tick(1);
            if (i < 6) `CHK("mode", ssc_sync_mode_t'(i / 2), mode)
            `CHK("edge", 1'(i % 2), edge_r)
            cmd_do(0, `SSC_CMD_SYNC_SETUP, 0);
        end
        repeat (6) begin
            d = 16'($urandom);
            if (d[15:8] == 8'h00 && d[4:0] == 5'h10) d[0] = 1'b1;
            cmd_do(1, `SSC_CMD_SYNC_SETUP, d);
            cmd_do(0, `SSC_CMD_SYNC_SETUP, 0);
        end
        $display("Test sync setup done");
        for (int i = 0; i < 16; i++) begin
            cmd_do(1, `SSC_CMD_STACK_SETUP, 16'(i));
            cmd_do(0, `SSC_CMD_STACK_SETUP, 0);
        end
        cmd_do(1, `SSC_CMD_STACK_SETUP, 16'($urandom) | 16'h0012);
        cmd_do(1, `SSC_CMD_STACK_SETUP, 3);
        conv <= 1'b1;
        tick(1);
        cmd_do(1, `SSC_CMD_STACK_SETUP, 1);
        cmd_do(0, `SSC_CMD_STACK_SETUP, 0);
        conv <= 1'b0;
        tick(20);
        `CHK("bcx oe", 2'b00, {pins.clk_oe, pins.dat_oe})
        d = 16'($urandom);
        cmd_do(1, `SSC_CMD_MISC_SETTINGS, d);
        tick(1);
        `CHK("misc out", d, misc)
        cmd_do(0, `SSC_CMD_MISC_SETTINGS, 0);
        cmd_do(1, 8'h5a, d);
        cmd_do(0, 8'h5a, 0);
        $display("Test stack and misc done");
        load <= {16'h1800, 8'h50, 8'hb0, 4'h1, 4'h2};
        tick(1);
        restore <= 1'b1;
        tick(1);
        restore <= 1'b0;
        tick(2);
        m_sync = 'hb0;
        m_last = 2;
        cmd_do(0, `SSC_CMD_SYNC_SETUP, 0);
        cmd_do(0, `SSC_CMD_STACK_SETUP, 0);
        `CHK("bcx oe", 2'b00, {pins.clk_oe, pins.dat_oe})
        $display("Test restore done");
        // Auto-detect: static low, static high, slow and fast toggling
        cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h00d0);
        for (int k = 0; k < 4; k++) begin
            run <= (k >= 2);
            level <= (k == 1);
            half <= (k == 2) ? 8'h28 : 8'h0a;
            tick(200);
            for (int w = 0; w < 200 && run && sync_pin !== 1'b1; w++) tick(1);
            for (int w = 0; w < 200 && run && sync_pin !== 1'b0; w++) tick(1);
            tick(3);
            conv <= 1'b1;
            tick(4);
            `CHK("auto mode", (k % 2) ? SSC_MODE_IN : SSC_MODE_OUT, mode)
            level <= ~level;
            tick(4);
            `CHK("auto held", (k % 2) ? SSC_MODE_IN : SSC_MODE_OUT, mode)
            conv <= 1'b0;
            run <= 1'b0;
            // Let the toggle detector forget the last edges, or a follower sees sync
            tick(64);
        end
        $display("Test auto-detect done");
        follower <= 1'b1;
        cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h0050);
        conv <= 1'b1;
        tick(3);
        `CHK("follower fault", 1'b1, fault)
        `CHK("follower mode", SSC_MODE_IN, mode)
        pulse_clr();
        `CHK("fault kept", 1'b1, fault)
        cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h0090);
        cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h0050);
        tick(2);
        `CHK("low rate on fault", 1'b1, low_rate)
        conv <= 1'b0;
        pulse_clr();
        `CHK("fault cleared", 1'b0, fault)
        run <= 1'b1;
        tick(100);
        conv <= 1'b1;
        tick(50);
        `CHK("sync present", 1'b0, fault)
        run <= 1'b0;
        tick(200);
        `CHK("sync lost", 1'b1, fault)
        conv <= 1'b0;
        follower <= 1'b0;
        pulse_clr();
        $display("Test follower done");
        for (int k = 0; k < 2; k++) begin
            cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h0090);
            conv <= 1'b1;
            low_lim <= 1'(k);
            tick(2);
            cmd_do(1, `SSC_CMD_SYNC_SETUP, 16'h0050);
            low_lim <= 1'b0;
            tick(5);
            `CHK("low rate", 1'(k), low_rate)
            conv <= 1'b0;
            tick(3);
            `CHK("low rate off", 1'b0, low_rate)
        end
        $display("Test low limit done");
        // Host stored index 3 with bit 12 clear and cycled the supply
        power_up(16'h0000, 4'h3, 4'h0);
        tick(40);
        `CHK("bcx oe", 2'b11, {pins.clk_oe, pins.dat_oe})
        `CHK("frame 3", 1'b1, rot_ok(hist, 3))
        for (int v = 1; v >= 0; v--) begin
            cmd_do(1, `SSC_CMD_STACK_SETUP, 16'(v));
            tick(40);
            `CHK("live frame", 1'b1, rot_ok(hist, v))
        end
        `CHK("bcx kept", 2'b11, {pins.clk_oe, pins.dat_oe})
        $display("Test backchannel done");
        summarize();
    end
endmodule // tb_ssc_top
